// ---- lrs_pkg.sv ----
package lrs_pkg;
  // Special-function register addresses
  localparam logic [7:0] LRS_LIN_CTRL_ADDR  = 8'hD9; // Control/status word
  localparam logic [7:0] LRS_RX_CFG_ADDR    = 8'hDA; // rx_input_config
  // Control/status field positions
  localparam int LRS_BIT_BREAK_FLAG  = 6;
  localparam int LRS_BIT_SYNC_TO     = 5;
  localparam int LRS_BIT_SYNC_FOUND  = 4;
  localparam int LRS_BIT_MODE        = 3;
  localparam int LRS_BIT_BREAK_IE    = 2;
  localparam int LRS_BIT_SYNC_TO_IE  = 1;
  localparam int LRS_BIT_SYNC_FD_IE  = 0;
  // rx_input_config field layout
  localparam int LRS_RXSRC_LSB       = 0;
  localparam int LRS_RXSRC_W         = 2;
  // Reset values
  localparam logic [7:0] LRS_CTRL_RESET  = 8'h00;
  localparam logic [1:0] LRS_RXSRC_RESET = 2'h0;
  // Receive source encodings
  typedef enum logic [1:0] {
    LRS_SRC_PIN  = 2'b00,
    LRS_SRC_LU0  = 2'b01,
    LRS_SRC_LU1  = 2'b10,
    LRS_SRC_LU2  = 2'b11
  } lrs_src_t;
endpackage

// ---- lrs_lin_irq_rx_sel.sv ----
// How it works
// - Mode bit demands break before sync/autobaud
// - Bit 2 gates break-done interrupt, reset 0
// - Bit 1 gates sync-timeout interrupt, reset 0
// - Bit 0 gates sync-found interrupt, reset 0
// - Bits 1:0 pick pin or logic unit
// - Break-done flag sticks until software clears
// - Sync-timeout flag set on sync field timeout
`timescale 1ns/100ps
`default_nettype none
module lrs_lin_irq_rx_sel (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  input  wire logic       break_seen,
  input  wire logic       sync_word_seen,
  input  wire logic       sync_timeout_seen,
  input  wire logic       rx_pin,
  input  wire logic       logic_unit_zero,
  input  wire logic       logic_unit_one,
  input  wire logic       logic_unit_two,
  input  wire logic       other_irq,
  output logic            rx_selected,
  output logic            break_before_sync_mode,
  output logic            sync_accept,
  output logic            serial_port_one_irq
);
  import lrs_pkg::*;

  // Register map in brief:
  //   control/status word: bit 6 break-done flag, bit 5 sync-timeout flag,
  //   bit 4 sync-found flag, bit 3 mode, bits 2..0 interrupt enables.
  //   rx_input_config: bits 1:0 pick the receive source, rest read 0.
  // Flags are set by hardware and cleared by writing 0; writing 1 also sets
  // them, which lets software test the interrupt path without a bus frame.
  // If a detector pulse and a clearing write meet in one cycle the pulse
  // wins, so an event is never lost to a read-modify-write race.
  // The interrupt and the receive mux are registered: each adds one cycle
  // of latency, traded for clean flop outputs at the block boundary.
  // Limitation: the armed state tracks breaks even with the mode bit off,
  // so turning the mode on right after a break accepts the next sync.
  // The receive mux holds the idle level 1 in reset so the receiver sees
  // no false start bit while the source field is still settling.
  // Reserved bits of both words read 0 and ignore writes; unmapped
  // addresses read 0 as well, so a stray read never returns stale data.
  // All registers run on every clock; there is no clock enable, and the
  // pin inputs are taken as already synchronous to clk.
  // Read data stands for one cycle after the read strobe and then
  // returns to 0, so a bus that latches late must not rely on it.
  // The sync_accept output is combinational: a detector downstream sees
  // the accepted pulse in the same cycle as the raw sync word.

  logic       break_done_flag_r;
  logic       sync_timeout_flag_r;
  logic       sync_found_flag_r;
  logic       mode_r;
  logic       break_done_irq_en_r;
  logic       sync_timeout_irq_en_r;
  logic       sync_found_irq_en_r;
  logic [1:0] rx_source_select_r;
  logic       armed_r;
  logic       armed_nxt;
  logic       rx_sel_nxt;
  logic [7:0] rdata_nxt;

  // Address decode
  wire wr_ctrl = sfr_wr && (sfr_addr == LRS_LIN_CTRL_ADDR);
  wire wr_cfg  = sfr_wr && (sfr_addr == LRS_RX_CFG_ADDR);
  wire rd_ctrl = sfr_rd && (sfr_addr == LRS_LIN_CTRL_ADDR);
  wire rd_cfg  = sfr_rd && (sfr_addr == LRS_RX_CFG_ADDR);

  // Sync is honoured only after a break when the mode bit is set
  assign sync_accept = sync_word_seen && (!mode_r || armed_r);
  assign armed_nxt   = break_seen ? 1'b1 :
                       (sync_accept || sync_timeout_seen) ? 1'b0 : armed_r;

  // Flags: hardware set wins over a software clear in the same cycle
  wire bd_nxt = break_seen ||
                (wr_ctrl ? sfr_wdata[LRS_BIT_BREAK_FLAG] : break_done_flag_r);
  wire to_nxt = sync_timeout_seen ||
                (wr_ctrl ? sfr_wdata[LRS_BIT_SYNC_TO] : sync_timeout_flag_r);
  wire sf_nxt = sync_accept ||
                (wr_ctrl ? sfr_wdata[LRS_BIT_SYNC_FOUND] : sync_found_flag_r);

  // Break-done flag; sticky until software writes the bit back to 0
  always_ff @(posedge clk) begin
    if (reset) begin
      break_done_flag_r <= LRS_CTRL_RESET[LRS_BIT_BREAK_FLAG];
    end else begin
      break_done_flag_r <= bd_nxt;
    end
  end

  // Sync-timeout flag; a later sync word does not hide a timeout
  always_ff @(posedge clk) begin
    if (reset) begin
      sync_timeout_flag_r <= LRS_CTRL_RESET[LRS_BIT_SYNC_TO];
    end else begin
      sync_timeout_flag_r <= to_nxt;
    end
  end

  // Sync-found flag; only accepted sync words set it
  always_ff @(posedge clk) begin
    if (reset) begin
      sync_found_flag_r <= LRS_CTRL_RESET[LRS_BIT_SYNC_FOUND];
    end else begin
      sync_found_flag_r <= sf_nxt;
    end
  end

  // Break-armed state for the break-before-sync mode
  always_ff @(posedge clk) begin
    if (reset) begin
      armed_r <= 1'b0;
    end else begin
      armed_r <= armed_nxt;
    end
  end

  // Mode bit; takes effect from the next sync word on
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_r <= LRS_CTRL_RESET[LRS_BIT_MODE];
    end else if (wr_ctrl) begin
      mode_r <= sfr_wdata[LRS_BIT_MODE];
    end
  end

  // Break-done interrupt enable
  always_ff @(posedge clk) begin
    if (reset) begin
      break_done_irq_en_r <= LRS_CTRL_RESET[LRS_BIT_BREAK_IE];
    end else if (wr_ctrl) begin
      break_done_irq_en_r <= sfr_wdata[LRS_BIT_BREAK_IE];
    end
  end

  // Sync-timeout interrupt enable
  always_ff @(posedge clk) begin
    if (reset) begin
      sync_timeout_irq_en_r <= LRS_CTRL_RESET[LRS_BIT_SYNC_TO_IE];
    end else if (wr_ctrl) begin
      sync_timeout_irq_en_r <= sfr_wdata[LRS_BIT_SYNC_TO_IE];
    end
  end

  // Sync-found interrupt enable
  always_ff @(posedge clk) begin
    if (reset) begin
      sync_found_irq_en_r <= LRS_CTRL_RESET[LRS_BIT_SYNC_FD_IE];
    end else if (wr_ctrl) begin
      sync_found_irq_en_r <= sfr_wdata[LRS_BIT_SYNC_FD_IE];
    end
  end

  // Receive source field; reserved bits ignore writes
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_source_select_r <= LRS_RXSRC_RESET;
    end else if (wr_cfg) begin
      rx_source_select_r <=
        sfr_wdata[LRS_RXSRC_LSB +: LRS_RXSRC_W];
    end
  end

  // Receive input mux
  assign rx_sel_nxt =
    (rx_source_select_r == LRS_SRC_LU0) ? logic_unit_zero :
    (rx_source_select_r == LRS_SRC_LU1) ? logic_unit_one  :
    (rx_source_select_r == LRS_SRC_LU2) ? logic_unit_two  :
                                          rx_pin;

  // Read data; one cycle latency, reserved bits zero
  assign rdata_nxt =
    rd_ctrl ? {1'b0, break_done_flag_r, sync_timeout_flag_r,
               sync_found_flag_r, mode_r, break_done_irq_en_r,
               sync_timeout_irq_en_r, sync_found_irq_en_r} :
    rd_cfg  ? {6'h00, rx_source_select_r} : 8'h00;

  // Per-source interrupt terms; a flag counts only while enabled
  wire irq_break   = break_done_flag_r   && break_done_irq_en_r;
  wire irq_timeout = sync_timeout_flag_r && sync_timeout_irq_en_r;
  wire irq_sync    = sync_found_flag_r   && sync_found_irq_en_r;
  wire irq_nxt     = other_irq || irq_break ||
                     irq_timeout || irq_sync;

  // Registered read data
  always_ff @(posedge clk) begin
    if (reset) begin
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rdata <= rdata_nxt;
    end
  end

  // Registered rx path; the mux adds one cycle, idles high in reset
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_selected <= 1'b1;
    end else begin
      rx_selected <= rx_sel_nxt;
    end
  end

  // Registered interrupt request; lags the flags by one cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      serial_port_one_irq <= 1'b0;
    end else begin
      serial_port_one_irq <= irq_nxt;
    end
  end

  // Mode level seen by the break and sync detectors
  assign break_before_sync_mode = mode_r;
endmodule
`default_nettype wire

// ---- lrs_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
module lrs_chk import lrs_pkg::*; (
  input wire logic       clk, reset, sfr_wr, sfr_rd, break_seen, other_irq,
  input wire logic       sync_word_seen, sync_timeout_seen, rx_pin,
  input wire logic       logic_unit_zero, logic_unit_one, logic_unit_two,
  input wire logic       rx_selected, sync_accept, break_before_sync_mode,
  input wire logic       serial_port_one_irq,
  input wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata
);
  logic [3:0] ctrl_r;
  logic [1:0] sel_r;
  wire  [3:0] cand = {logic_unit_two, logic_unit_one, logic_unit_zero, rx_pin};
  wire        pick = cand[sel_r];
  // Shadow copies of the writable control bits and the source field
  always_ff @(posedge clk) begin
    ctrl_r <= reset ? 4'h0 : (sfr_wr && sfr_addr == LRS_LIN_CTRL_ADDR) ?
              sfr_wdata[3:0] : ctrl_r;
    sel_r <= reset ? 2'h0 : (sfr_wr && sfr_addr == LRS_RX_CFG_ADDR) ?
             sfr_wdata[1:0] : sel_r;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_rx_pick: assert property (
    !$past(reset) |-> rx_selected == $past(pick))
    else $error("wrong rx source");
  a_cfg_read: assert property (
    sfr_rd && sfr_addr == LRS_RX_CFG_ADDR |=>
    sfr_rdata == {6'h00, $past(sel_r)}) else $error("bad cfg read");
  a_mode_bit: assert property (break_before_sync_mode == ctrl_r[3])
    else $error("mode level wrong");
  a_sync_pass: assert property (
    sync_word_seen && !ctrl_r[3] |-> sync_accept)
    else $error("sync dropped");
  a_irq_quiet: assert property (
    $past(ctrl_r[2:0] == 3'h0 && !other_irq) |-> !serial_port_one_irq)
    else $error("irq while disabled");
  a_break_irq: assert property (break_seen && ctrl_r[2] |->
    ##2 serial_port_one_irq [*2]) else $error("no break irq");
  a_sync_irq: assert property (
    sync_accept && ctrl_r[0] || sync_timeout_seen && ctrl_r[1]
    |-> ##2 serial_port_one_irq) else $error("no sync irq");
  a_other_irq: assert property (other_irq |=> serial_port_one_irq)
    else $error("other source lost");
endmodule
bind lrs_lin_irq_rx_sel lrs_chk u_chk (.*);
`default_nettype wire

// ---- lrs_far_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module lrs_far (
  input  wire logic clk,
  output logic      rx_pin, logic_unit_zero, logic_unit_one, logic_unit_two
);
  // Levels are redrawn at random each cycle, so a stale pick is unlikely to pass every check
  initial {rx_pin, logic_unit_zero, logic_unit_one, logic_unit_two} = 4'h0;
  always @(posedge clk) begin
    {logic_unit_two, logic_unit_one, logic_unit_zero, rx_pin} <= 4'($urandom);
  end
endmodule
`default_nettype wire

// ---- lrs_lin_irq_rx_sel_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module lrs_lin_irq_rx_sel_bench;
  import lrs_pkg::*;
  logic clk = 0, reset = 1, sfr_wr = 0, sfr_rd = 0, other_irq = 0;
  logic break_seen = 0, sync_word_seen = 0, sync_timeout_seen = 0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, v;
  logic [3:0] lvp;
  wire logic [7:0] sfr_rdata;
  wire logic rx_pin, logic_unit_zero, logic_unit_one, logic_unit_two;
  wire logic rx_selected, break_before_sync_mode, sync_accept;
  wire logic serial_port_one_irq;
  int fail_count = 0, n_tests = 0, cyc = 0;
  initial forever #2.5 clk = ~clk;
  lrs_far u_far (.*);
  lrs_lin_irq_rx_sel u_dut (.*);
  function automatic logic [7:0] cfg_exp(logic [7:0] w);
    return {6'h00, w[1:0]};
  endfunction
  // Old levels are caught at the edge, before the far side moves them
  task tick; @(posedge clk); lvp = {logic_unit_two, logic_unit_one,
    logic_unit_zero, rx_pin}; #1; endtask
  task chk(string n, logic [7:0] e, s); n_tests++; if (s !== e) begin
    fail_count++; $display("wrong value %s exp %h seen %h", n, e, s); end
  endtask
  task wr_(logic [7:0] ad, dt); sfr_addr = ad; sfr_wdata = dt; sfr_wr = 1;
    tick; sfr_wr = 0; endtask
  task rd_(logic [7:0] ad, e); sfr_addr = ad; sfr_rd = 1; tick; sfr_rd = 0;
    chk("rdata", e, sfr_rdata); endtask
  task finish_test; $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish; endtask
  always @(posedge clk) if (++cyc > 2000) begin fail_count++; finish_test; end
  initial begin
    void'($urandom(32'hE402));
    repeat (20) tick;
    reset = 0;
    rd_(LRS_LIN_CTRL_ADDR, LRS_CTRL_RESET);
    rd_(LRS_RX_CFG_ADDR, 8'h00);
    break_seen = 1; tick; break_seen = 0; tick; tick;
    chk("irq", 0, serial_port_one_irq);
    rd_(LRS_LIN_CTRL_ADDR, 8'h40);
    for (int i = 0; i < 12; i++) begin
      v = {6'($urandom), 2'(i)};
      wr_(LRS_RX_CFG_ADDR, v);
      rd_(LRS_RX_CFG_ADDR, cfg_exp(v));
      chk("rx", lvp[v[1:0]], rx_selected);
    end
    rd_(8'h5C, 8'h00);
    $display("test source select done");
    // Sync goes last, so no break stays armed for the mode test
    for (int i = 2; i >= 0; i--) begin
      wr_(LRS_LIN_CTRL_ADDR, 8'(1 << i));
      break_seen = i == 2; sync_timeout_seen = i == 1; sync_word_seen = i == 0;
      tick; {break_seen, sync_timeout_seen, sync_word_seen} = 3'h0; tick;
      chk("irq", 1, serial_port_one_irq);
      wr_(LRS_LIN_CTRL_ADDR, 8'h00); tick;
    end
    wr_(LRS_LIN_CTRL_ADDR, 8'h08);
    sync_word_seen = 1; #1 chk("accept", 0, sync_accept);
    tick; sync_word_seen = 0; break_seen = 1; tick; break_seen = 0;
    sync_word_seen = 1; #1 chk("accept", 1, sync_accept);
    tick; sync_word_seen = 0; other_irq = 1; tick; tick;
    chk("irq", 1, serial_port_one_irq);
    $display("test interrupts and mode done");
    finish_test;
  end
endmodule
`default_nettype wire
